// ===== hw/ext_interrupt_flag_and_response.sv
`timescale 1ns/1ps
`include "ext_irq_regs.svh"
// Summary of operation
// - wait 1 to 13 states for instruction end
// - push 4 states, vector fetch 2 states
// - fetch 4, internal 4, then handler
// - word access forces address bit zero
// - all stack transfers are word size
// - save full word, restore even byte
// - function 0 to 1, low, polarity 0 sets
// - function 1 to 0, low, polarity 1 sets
// - wake function 0 to 1, pin low sets
// - clear right after function write ignored
// - wake falling edge sets wake flag
// - wake flag clears only by writing 0
module ext_interrupt_flag_and_response (
    // clock and reset
    input  wire logic                 clock,
    input  wire logic                 rst,
    // apb slave
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [11:0]          paddr,
    input  wire logic [31:0]          pwdata,
    output logic      [31:0]          prdata,
    output logic                      pready,
    output logic                      pslverr,
    // external pins, active low requests
    input  wire logic [4:0]           ext_pin_n,
    input  wire logic [7:0]           wake_pin_n,
    // interrupt and exception status
    output logic                      irq,
    output logic                      in_handler,
    output ext_irq_pkg::stack_access_t stack_bus
);
    // pin synchronisers
    logic [4:0]  ext_meta, ext_sync, ext_prev;
    logic [7:0]  wake_meta, wake_sync, wake_prev;
    // software-visible registers
    logic [4:0]  ext_request_flag_reg;         // request flags
    logic [7:0]  wake_request_flag_reg;        // wake flags
    logic [4:0]  pin_function_reg_a;           // pins 1..3 use this
    logic [4:0]  pin_function_reg_b;           // pins 0 and 4 use this
    logic [7:0]  wake_function_reg;            // wake pin enables
    logic [4:0]  edge_polarity_reg;            // 1 = rising edge
    logic [12:0] irq_mask;                     // 1 = enabled
    logic [7:0]  cond_code_reg;                // condition codes
    logic [15:0] stack_ptr;                    // stack pointer
    // sequencer state
    ext_irq_pkg::phase_t phase;
    logic [3:0]  state_cnt;                    // states left in phase
    logic [3:0]  wait_len;                     // programmed wait
    logic        func_guard;                   // last access hit a function reg
    // decoded apb strobes
    logic        wr, rd;
    logic [4:0]  func_eff, next_func_eff;      // per-pin effective function
    logic [4:0]  ext_set;
    logic [7:0]  wake_set;
    logic        hit;

    assign wr      = psel && penable && pwrite;
    assign rd      = psel && penable && !pwrite;
    assign pready  = 1'b1;

    // two-flop synchronisers, then one more stage for edges
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            ext_meta  <= 5'h1f;
            ext_sync  <= 5'h1f;
            ext_prev  <= 5'h1f;
            wake_meta <= 8'hff;
            wake_sync <= 8'hff;
            wake_prev <= 8'hff;
        end else begin
            ext_meta  <= ext_pin_n;
            ext_sync  <= ext_meta;
            ext_prev  <= ext_sync;
            wake_meta <= wake_pin_n;
            wake_sync <= wake_meta;
            wake_prev <= wake_sync;
        end
    end

    // effective function bit per pin, split across two registers
    always_comb begin
        func_eff = {pin_function_reg_b[4], pin_function_reg_a[3:1], pin_function_reg_b[0]};
        next_func_eff = func_eff;
        if (wr && paddr == `OFS_FUNC_A) begin
            next_func_eff[3:1] = pwdata[3:1];
        end
        if (wr && paddr == `OFS_FUNC_B) begin
            next_func_eff[4] = pwdata[4];
            next_func_eff[0] = pwdata[0];
        end
    end

    // set conditions: real edges plus spurious sets on function switch
    always_comb begin
        for (int i = 0; i < `EXT_PINS; i++) begin
            ext_set[i] = func_eff[i] && (edge_polarity_reg[i] ? (!ext_prev[i] && ext_sync[i])
                                                             : (ext_prev[i] && !ext_sync[i]));
            // low pin looks like an edge when the function turns on with falling polarity
            if (!func_eff[i] && next_func_eff[i] && !ext_sync[i] && !edge_polarity_reg[i]) begin
                ext_set[i] = 1'b1;
            end
            // and when it turns off with rising polarity
            if (func_eff[i] && !next_func_eff[i] && !ext_sync[i] && edge_polarity_reg[i]) begin
                ext_set[i] = 1'b1;
            end
        end
        for (int j = 0; j < `WAKE_PINS; j++) begin
            wake_set[j] = wake_function_reg[j] && wake_prev[j] && !wake_sync[j];
            if (wr && paddr == `OFS_WAKE_FUNC && !wake_function_reg[j] && pwdata[j] && !wake_sync[j]) begin
                wake_set[j] = 1'b1;
            end
        end
    end

    // remembers a function-register access for the next access
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            func_guard <= 1'b0;
        end else if (psel && penable) begin
            func_guard <= (paddr == `OFS_FUNC_A || paddr == `OFS_FUNC_B || paddr == `OFS_WAKE_FUNC);
        end
    end

    // flag registers: set wins, write 0 clears, write 1 keeps
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            ext_request_flag_reg  <= 5'h00;
            wake_request_flag_reg <= `RST_ZERO8;
        end else begin
            // a clear straight after a function access is dropped
            if (wr && paddr == `OFS_EXT_FLAG && !func_guard) begin
                ext_request_flag_reg <= (ext_request_flag_reg & pwdata[4:0]) | ext_set;
            end else begin
                ext_request_flag_reg <= ext_request_flag_reg | ext_set;
            end
            if (wr && paddr == `OFS_WAKE_FLAG && !func_guard) begin
                wake_request_flag_reg <= (wake_request_flag_reg & pwdata[7:0]) | wake_set;
            end else begin
                wake_request_flag_reg <= wake_request_flag_reg | wake_set;
            end
        end
    end

    // configuration registers
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            pin_function_reg_a <= 5'h00;
            pin_function_reg_b <= 5'h00;
            wake_function_reg  <= `RST_ZERO8;
            edge_polarity_reg  <= 5'h00;
            irq_mask           <= 13'h0000;
            wait_len           <= `ST_WAIT_MIN;
        end else if (wr) begin
            unique case (paddr)
                `OFS_FUNC_A:    pin_function_reg_a <= pwdata[4:0];
                `OFS_FUNC_B:    pin_function_reg_b <= pwdata[4:0];
                `OFS_WAKE_FUNC: wake_function_reg  <= pwdata[7:0];
                `OFS_EDGE_POL:  edge_polarity_reg  <= pwdata[4:0];
                `OFS_IRQ_MASK:  irq_mask           <= pwdata[12:0];
                `OFS_EXC_CTRL: begin
                    // clamp wait to the legal 1..13 range
                    if (pwdata[11:8] < `ST_WAIT_MIN) begin
                        wait_len <= `ST_WAIT_MIN;
                    end else if (pwdata[11:8] > `ST_WAIT_MAX) begin
                        wait_len <= `ST_WAIT_MAX;
                    end else begin
                        wait_len <= pwdata[11:8];
                    end
                end
                default: ;
            endcase
        end
    end

    // one level interrupt while any enabled flag is set and i bit clear
    assign irq = |({wake_request_flag_reg, ext_request_flag_reg} & irq_mask) && !cond_code_reg[7];
    // exception entry sequencer, one state per clock
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            phase     <= ext_irq_pkg::ph_idle;
            state_cnt <= 4'd0;
        end else begin
            unique case (phase)
                ext_irq_pkg::ph_idle: begin
                    if (irq) begin
                        phase     <= ext_irq_pkg::ph_wait;
                        state_cnt <= wait_len;
                    end
                end
                ext_irq_pkg::ph_wait: begin
                    if (state_cnt == 4'd1) begin
                        phase     <= ext_irq_pkg::ph_save;
                        state_cnt <= `ST_SAVE;
                    end else begin
                        state_cnt <= state_cnt - 4'd1;
                    end
                end
                ext_irq_pkg::ph_save: begin
                    if (state_cnt == 4'd1) begin
                        phase     <= ext_irq_pkg::ph_vector;
                        state_cnt <= `ST_VECTOR;
                    end else begin
                        state_cnt <= state_cnt - 4'd1;
                    end
                end
                ext_irq_pkg::ph_vector: begin
                    if (state_cnt == 4'd1) begin
                        phase     <= ext_irq_pkg::ph_fetch;
                        state_cnt <= `ST_FETCH;
                    end else begin
                        state_cnt <= state_cnt - 4'd1;
                    end
                end
                ext_irq_pkg::ph_fetch: begin
                    if (state_cnt == 4'd1) begin
                        phase     <= ext_irq_pkg::ph_internal;
                        state_cnt <= `ST_INTERNAL;
                    end else begin
                        state_cnt <= state_cnt - 4'd1;
                    end
                end
                ext_irq_pkg::ph_internal: begin
                    if (state_cnt == 4'd1) begin
                        phase <= ext_irq_pkg::ph_handler;
                    end else begin
                        state_cnt <= state_cnt - 4'd1;
                    end
                end
                ext_irq_pkg::ph_handler: begin
                    // leave when software requests the exception return
                    if (wr && paddr == `OFS_EXC_CTRL && pwdata[`EXC_RETURN_BIT]) begin
                        phase <= ext_irq_pkg::ph_idle;
                    end
                end
            endcase
        end
    end
    assign in_handler = (phase == ext_irq_pkg::ph_handler);
    // stack pointer, i bit and word-size stack bus
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            stack_ptr     <= `RST_SP;
            cond_code_reg <= `RST_ZERO8;
            stack_bus     <= '0;
        end else begin
            stack_bus.valid <= 1'b0;
            if (wr && paddr == `OFS_STACK) begin
                stack_ptr <= pwdata[15:0];
            end
            // first save state pushes a full word holding the codes
            if (phase == ext_irq_pkg::ph_save && state_cnt == `ST_SAVE) begin
                stack_bus.valid <= 1'b1;
                stack_bus.write <= 1'b1;
                stack_bus.addr  <= {stack_ptr[15:1] - 15'd1, 1'b0};
                stack_bus.data  <= {cond_code_reg, cond_code_reg};
                stack_ptr       <= {stack_ptr[15:1] - 15'd1, 1'b0};
                cond_code_reg   <= cond_code_reg | 8'h80;
            end
            // return pops one word; the odd byte is dropped
            if (phase == ext_irq_pkg::ph_handler && wr && paddr == `OFS_EXC_CTRL && pwdata[`EXC_RETURN_BIT]) begin
                stack_bus.valid <= 1'b1;
                stack_bus.write <= 1'b0;
                stack_bus.addr  <= {stack_ptr[15:1], 1'b0};
                stack_bus.data  <= {pwdata[31:24], pwdata[23:16]};
                stack_ptr       <= {stack_ptr[15:1] + 15'd1, 1'b0};
                cond_code_reg   <= pwdata[31:24];
            end
        end
    end

    // read mux, unmapped addresses flag an error
    always_comb begin
        prdata  = 32'h00000000;
        hit     = 1'b1;
        unique case (paddr)
            `OFS_EXT_FLAG:   prdata[4:0]  = ext_request_flag_reg;
            `OFS_WAKE_FLAG:  prdata[7:0]  = wake_request_flag_reg;
            `OFS_FUNC_A:     prdata[4:0]  = pin_function_reg_a;
            `OFS_FUNC_B:     prdata[4:0]  = pin_function_reg_b;
            `OFS_WAKE_FUNC:  prdata[7:0]  = wake_function_reg;
            `OFS_EDGE_POL:   prdata[4:0]  = edge_polarity_reg;
            `OFS_IRQ_MASK:   prdata[12:0] = irq_mask;
            `OFS_EXC_CTRL:   prdata[11:8] = wait_len;
            `OFS_EXC_STATUS: prdata[15:0] = {cond_code_reg, 1'b0, phase, state_cnt};
            `OFS_STACK:      prdata[15:0] = stack_ptr;
            default:         hit          = 1'b0;
        endcase
    end
    assign pslverr = psel && penable && !hit;

    // save phase lasts exactly four states
    property p_save_len;
        @(posedge clock) disable iff (rst)
        $rose(phase == ext_irq_pkg::ph_save) |-> (phase == ext_irq_pkg::ph_save)[*4] ##1
                                                 (phase == ext_irq_pkg::ph_vector);
    endproperty
    a_save_len: assert property (p_save_len) else $error("save phase length wrong");
    sequence s_vec2;
        (phase == ext_irq_pkg::ph_vector)[*2];
    endsequence
    sequence s_tail;
        (phase == ext_irq_pkg::ph_fetch)[*4] ##1 (phase == ext_irq_pkg::ph_internal)[*4];
    endsequence
    property p_tail;
        @(posedge clock) disable iff (rst)
        $rose(phase == ext_irq_pkg::ph_vector) |-> s_vec2 ##1 s_tail ##1 in_handler;
    endproperty
    a_tail: assert property (p_tail) else $error("vector or fetch timing wrong");
    property p_wait_bound;
        @(posedge clock) disable iff (rst)
        $rose(phase == ext_irq_pkg::ph_wait) |-> ##[1:13] (phase == ext_irq_pkg::ph_save);
    endproperty
    a_wait_bound: assert property (p_wait_bound) else $error("wait exceeds bound");
    property p_even_addr;
        @(posedge clock) disable iff (rst)
        stack_bus.valid |-> !stack_bus.addr[0];
    endproperty
    a_even_addr: assert property (p_even_addr) else $error("odd stack address");
    property p_push_word;
        @(posedge clock) disable iff (rst)
        (stack_bus.valid && stack_bus.write) |-> stack_bus.data[15:8] == stack_bus.data[7:0];
    endproperty
    a_push_word: assert property (p_push_word) else $error("push word halves differ");
    property p_guard_clear;
        @(posedge clock) disable iff (rst)
        (func_guard && wr && paddr == `OFS_WAKE_FLAG) |=> ((wake_request_flag_reg & $past(wake_request_flag_reg))
                                                          == $past(wake_request_flag_reg));
    endproperty
    a_guard_clear: assert property (p_guard_clear) else $error("guarded clear took effect");
    property p_wake_sticky;
        @(posedge clock) disable iff (rst)
        !(wr && paddr == `OFS_WAKE_FLAG) |=> (wake_request_flag_reg & $past(wake_request_flag_reg))
                                             == $past(wake_request_flag_reg);
    endproperty
    a_wake_sticky: assert property (p_wake_sticky) else $error("wake flag lost");
    property p_spur0;
        @(posedge clock) disable iff (rst)
        (wr && paddr == `OFS_FUNC_B && !pin_function_reg_b[0] && pwdata[0] && !ext_sync[0]
         && !edge_polarity_reg[0]) |=> ext_request_flag_reg[0];
    endproperty
    a_spur0: assert property (p_spur0) else $error("spurious set missing");
    property p_spur4;
        @(posedge clock) disable iff (rst)
        (wr && paddr == `OFS_FUNC_B && pin_function_reg_b[4] && !pwdata[4] && !ext_sync[4]
         && edge_polarity_reg[4]) |=> ext_request_flag_reg[4];
    endproperty
    a_spur4: assert property (p_spur4) else $error("off-switch set missing");
    property p_wake_spur;
        @(posedge clock) disable iff (rst)
        (wr && paddr == `OFS_WAKE_FUNC && !wake_function_reg[7] && pwdata[7] && !wake_sync[7])
        |=> wake_request_flag_reg[7];
    endproperty
    a_wake_spur: assert property (p_wake_spur) else $error("wake switch set missing");
    property p_wake_edge;
        @(posedge clock) disable iff (rst)
        (wake_function_reg[0] && wake_prev[0] && !wake_sync[0]) |=> wake_request_flag_reg[0];
    endproperty
    a_wake_edge: assert property (p_wake_edge) else $error("wake edge missed");
endmodule

// ===== hw/ext_irq_regs.svh
`ifndef EXT_IRQ_REGS_SVH
`define EXT_IRQ_REGS_SVH
// apb byte offsets
`define OFS_EXT_FLAG     12'h000
`define OFS_WAKE_FLAG    12'h004
`define OFS_FUNC_A       12'h008
`define OFS_FUNC_B       12'h00c
`define OFS_WAKE_FUNC    12'h010
`define OFS_EDGE_POL     12'h014
`define OFS_IRQ_MASK     12'h018
`define OFS_EXC_CTRL     12'h01c
`define OFS_EXC_STATUS   12'h020
`define OFS_STACK        12'h024
// field positions and widths
`define EXT_PINS         5
`define WAKE_PINS        8
`define EXC_START_BIT    0
`define EXC_RETURN_BIT   1
`define EXC_WAIT_LSB     8
// reset values
`define RST_ZERO8        8'h00
`define RST_SP           16'h0100
// state counts per phase
`define ST_SAVE          4'd4
`define ST_VECTOR        4'd2
`define ST_FETCH         4'd4
`define ST_INTERNAL      4'd4
`define ST_WAIT_MIN      4'd1
`define ST_WAIT_MAX      4'd13
`endif

// ===== hw/ext_irq_pkg.sv
package ext_irq_pkg;
    // exception-entry sequencer phases
    typedef enum logic [2:0] {
        ph_idle,
        ph_wait,
        ph_save,
        ph_vector,
        ph_fetch,
        ph_internal,
        ph_handler
    } phase_t;
    // one word-size stack access
    typedef struct packed {
        logic        valid;
        logic        write;
        logic [15:0] addr;
        logic [15:0] data;
    } stack_access_t;
endpackage

// ===== verification/pin_source_model.sv
`timescale 1ns/1ps
// far-side pin sources: the bench asks for levels, the model drives them on the clock
module pin_source_model (
    // clock and reset
    input  wire logic       clock,
    input  wire logic       rst,
    // requested pin levels from the bench
    input  wire logic [4:0] ext_drive,
    input  wire logic [7:0] wake_drive,
    // pins toward the device, active low
    output logic      [4:0] ext_pin_n,
    output logic      [7:0] wake_pin_n
);
    // pins rest high, so a function switch never sees a low pin by accident
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            ext_pin_n  <= 5'h1f;
            wake_pin_n <= 8'hff;
        end else begin
            // a low request gives the device a falling edge
            ext_pin_n  <= ext_drive;
            wake_pin_n <= wake_drive;
        end
    end
endmodule

// ===== verification/tb_top.sv
`timescale 1ns/1ps
`include "ext_irq_regs.svh"
// apb-driven bench for the external request flags and the exception sequencer
module tb_top;
    logic                       clock;       // 100 MHz system clock
    logic                       rst;         // active high reset
    logic                       psel;        // apb select
    logic                       penable;     // apb access phase
    logic                       pwrite;      // apb direction
    logic [11:0]                paddr;       // apb byte address
    logic [31:0]                pwdata;      // apb write data
    logic [31:0]                prdata;      // apb read data
    logic                       pready;      // apb ready
    logic                       pslverr;     // apb error
    logic [4:0]                 ext_drive;   // requested external pin levels
    logic [7:0]                 wake_drive;  // requested wake pin levels
    logic [4:0]                 ext_pin_n;   // external pins
    logic [7:0]                 wake_pin_n;  // wake pins
    logic                       irq;         // interrupt request
    logic                       in_handler;  // handler phase flag
    ext_irq_pkg::stack_access_t stack_bus;   // word stack accesses
    logic [31:0]                rd;          // last read data
    logic                       rd_err;      // last read error
    logic [15:0]                pop_addr;    // address of the last stack pop
    int                         failures;    // mismatch count
    int                         n_compared;  // comparison count

    ext_interrupt_flag_and_response uut (.clock(clock), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .ext_pin_n(ext_pin_n), .wake_pin_n(wake_pin_n), .irq(irq),
        .in_handler(in_handler), .stack_bus(stack_bus));
    pin_source_model pins (.clock(clock), .rst(rst), .ext_drive(ext_drive), .wake_drive(wake_drive),
        .ext_pin_n(ext_pin_n), .wake_pin_n(wake_pin_n));

    // free-running clock
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    // compare and count
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // one apb transfer, held until pready is sampled high
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge clock);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clock);
        penable <= 1'b1;
        do @(posedge clock); while (pready !== 1'b1);
        rd      = prdata;
        rd_err  = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    // read one register and compare it
    task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        check(rd, exp);
    endtask

    // wait out pin synchronisation, longer than the three-edge latency
    task automatic settle();
        repeat (6) @(posedge clock);
    endtask

    // follow one exception entry up to the handler, watching stack words
    task automatic exc_run(input int w, input logic [15:0] exp_data);
        int          c;
        logic [15:0] wa;
        logic [15:0] wd;
        c  = 0;
        wa = 16'hffff;
        wd = 16'hffff;
        // the pop pulse of a return write stands only in the cycle after that write
        #1;
        if (stack_bus.valid === 1'b1 && stack_bus.write === 1'b0) pop_addr = stack_bus.addr;
        do begin
            @(posedge clock);
            #1;
            c++;
            if (stack_bus.valid === 1'b1 && stack_bus.write === 1'b1) begin
                wa = stack_bus.addr;
                wd = stack_bus.data;
            end
            if (stack_bus.valid === 1'b1 && stack_bus.write === 1'b0) begin
                pop_addr = stack_bus.addr;
            end
        end while (in_handler !== 1'b1 && c < 100);
        check(32'(c >= w + 14 && c <= w + 16), 32'h1);
        check(32'(wa), 32'h00fe);
        check(32'(wd), 32'(exp_data));
        check(32'(irq), 32'h0);
    endtask

    // verdict, reached from the sequence end and from the watchdog
    task automatic stop_test();
        $display("compared %0d, mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    // watchdog against a hang
    initial begin
        repeat (20000) @(posedge clock);
        failures++;
        stop_test();
    end

    // main sequence
    initial begin
        failures = 0;
        n_compared = 0;
        pop_addr = 16'hffff;
        rst = 1'b1;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        ext_drive = 5'h1f;
        wake_drive = 8'hff;
        repeat (16) @(posedge clock);
        rst <= 1'b0;
        // reset values and an unmapped place
        rd_chk(`OFS_EXT_FLAG, 32'h0);
        rd_chk(`OFS_WAKE_FLAG, 32'h0);
        rd_chk(`OFS_IRQ_MASK, 32'h0);
        rd_chk(`OFS_STACK, 32'h0100);
        rd_chk(12'h030, 32'h0);
        check(32'(rd_err), 32'h1);
        $display("test reset done");
        // real falling edge on an enabled wake pin
        apb(1'b1, `OFS_WAKE_FUNC, 32'hff);
        rd_chk(`OFS_WAKE_FLAG, 32'h0);
        wake_drive <= 8'hfe;
        settle();
        rd_chk(`OFS_WAKE_FLAG, 32'h01);
        apb(1'b1, `OFS_WAKE_FLAG, 32'hff);
        rd_chk(`OFS_WAKE_FLAG, 32'h01);
        wake_drive <= 8'hff;
        apb(1'b1, `OFS_WAKE_FLAG, 32'h0);
        rd_chk(`OFS_WAKE_FLAG, 32'h0);
        $display("test wake edge done");
        // spurious wake set and a clear lost right after the switch
        apb(1'b1, `OFS_WAKE_FUNC, 32'h00);
        wake_drive <= 8'h7f;
        settle();
        apb(1'b1, `OFS_WAKE_FUNC, 32'h80);
        apb(1'b1, `OFS_WAKE_FLAG, 32'h0);
        rd_chk(`OFS_WAKE_FLAG, 32'h80);
        apb(1'b1, `OFS_WAKE_FLAG, 32'h0);
        rd_chk(`OFS_WAKE_FLAG, 32'h0);
        wake_drive <= 8'hff;
        $display("test wake switch done");
        // spurious external sets for both polarities, pins 1..3 held high
        apb(1'b1, `OFS_EDGE_POL, 32'h10);
        ext_drive <= 5'h0e;
        settle();
        apb(1'b1, `OFS_FUNC_B, 32'h10);
        rd_chk(`OFS_EXT_FLAG, 32'h0);
        apb(1'b1, `OFS_FUNC_B, 32'h01);
        apb(1'b1, `OFS_FUNC_A, 32'h0e);
        rd_chk(`OFS_EXT_FLAG, 32'h11);
        ext_drive <= 5'h1f;
        check(32'(irq), 32'h0);
        $display("test ext switch done");
        // shortest wait, then return straight into a re-entry with the longest wait
        apb(1'b1, `OFS_EXC_CTRL, 32'h0100);
        apb(1'b1, `OFS_IRQ_MASK, 32'h001);
        exc_run(1, 16'h0000);
        apb(1'b1, `OFS_EXC_CTRL, 32'h0d00);
        apb(1'b1, `OFS_EXC_CTRL, 32'h5aa50d02);
        exc_run(13, 16'h5a5a);
        check(32'(pop_addr), 32'h00fe);
        apb(1'b0, `OFS_EXC_STATUS, 32'h0);
        check(32'(rd[15:8]), 32'h00da);
        apb(1'b1, `OFS_IRQ_MASK, 32'h000);
        apb(1'b1, `OFS_EXT_FLAG, 32'h0);
        rd_chk(`OFS_EXT_FLAG, 32'h0);
        pop_addr = 16'hffff;
        apb(1'b1, `OFS_EXC_CTRL, 32'h00000d02);
        repeat (3) begin
            #1;
            if (stack_bus.valid === 1'b1 && stack_bus.write === 1'b0) pop_addr = stack_bus.addr;
            @(posedge clock);
        end
        check(32'(pop_addr), 32'h00fe);
        rd_chk(`OFS_STACK, 32'h0100);
        check(32'({irq, in_handler}), 32'h0);
        $display("test exception done");
        stop_test();
    end
endmodule
